// ==== hw/umg_pkg.sv ====
// shared constants of the udp message gateway
package umg_pkg;
  // command header byte offsets
  localparam logic [3:0] CMD_OFS_SEQ   = 4'h0;
  localparam logic [3:0] CMD_OFS_TMO   = 4'h2;
  localparam logic [3:0] CMD_OFS_SIZE  = 4'h4;
  localparam logic [3:0] CMD_OFS_NODE  = 4'h6;
  localparam logic [3:0] CMD_OFS_SVC   = 4'h7;
  localparam logic [3:0] CMD_OFS_CLASS = 4'h8;
  localparam logic [3:0] CMD_OFS_INST  = 4'ha;
  localparam logic [3:0] CMD_OFS_DATA  = 4'hc;
  // response header byte offsets
  localparam logic [3:0] RSP_OFS_SEQ   = 4'h0;
  localparam logic [3:0] RSP_OFS_SIZE  = 4'h2;
  localparam logic [3:0] RSP_OFS_NODE  = 4'h4;
  localparam logic [3:0] RSP_OFS_SVC   = 4'h5;
  localparam logic [3:0] RSP_OFS_DATA  = 4'h6;
  // sizes and ranges
  localparam int          CMD_MAX_DATA = 492;
  localparam int          RSP_MAX_DATA = 496;
  localparam logic [15:0] CMD_SIZE_MIN = 16'h0006;
  localparam logic [15:0] CMD_SIZE_MAX = 16'h01f2;
  localparam logic [15:0] RSP_SIZE_MIN = 16'h0002;
  localparam logic [15:0] RSP_ERR_SIZE = 16'h0004;
  localparam logic [7:0]  NODE_MAX     = 8'h3f;
  // service byte coding
  localparam logic [7:0]  SVC_OK_BIT   = 8'h80;
  localparam logic [7:0]  SVC_ERR      = 8'h94;
  // fixed udp port, 64000
  localparam logic [15:0] UDP_PORT     = 16'hfa00;
  localparam int          NSLOT        = 4;
  // timing
  localparam int          CLK_PERIOD_NS = 5;
  localparam int          TMO_UNIT_MS   = 10;
  localparam int          TMO_DEF_MS    = 10_000;
  localparam int          TMO_MAX_S     = 655;
  localparam logic [15:0] TMO_DEF_UNITS = 16'(TMO_DEF_MS / TMO_UNIT_MS);
  localparam int          TMO_UNIT_CYC  =
    (TMO_UNIT_MS * 1_000_000) / CLK_PERIOD_NS;
endpackage : umg_pkg

// ==== hw/umg_slot_timer.sv ====
// per-buffer reply timeout counter, counts 10 ms ticks
`timescale 1ns/100ps
module umg_slot_timer (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  // control
  input  wire logic        tick_i,
  input  wire logic        start_i,
  input  wire logic [15:0] load_i,
  input  wire logic        stop_i,
  // result
  output logic             expire_o
);
  logic        run_q;
  logic [15:0] cnt_q;
  logic        expire_q;

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      run_q <= 1'b0;
      cnt_q <= 16'h0000;
    end else if (start_i) begin
      run_q <= 1'b1;
      cnt_q <= load_i;
    end else if (stop_i) begin
      run_q <= 1'b0;
    end else if (run_q && tick_i) begin
      // first tick may come early: up to one unit short
      if (cnt_q == 16'h0001) begin
        run_q <= 1'b0;
      end
      cnt_q <= cnt_q - 16'h0001;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      expire_q <= 1'b0;
    end else begin
      expire_q <= run_q && tick_i && !start_i && !stop_i
                  && (cnt_q == 16'h0001);
    end
  end

  assign expire_o = expire_q;
endmodule : umg_slot_timer

// ==== hw/umg_gateway.sv ====
// udp command to fieldbus request gateway with response framing
`timescale 1ns/100ps
// Functional notes
// - multi-byte fields are little-endian, low byte at lower offset.
// - command: seq 0, timeout 2, size 4, node 6, svc 7, class 8, inst 10.
// - accepted command is sent as request to the named node.
// - own controller is reached by its node address, same path.
// - sequence number is echoed unchanged in the response.
// - timeout counts 10 ms units; zero selects 10 s.
// - command size counts node through payload, valid 6 to 498.
// - destination node must be 0 to 63.
// - service, class and instance forwarded unaltered.
// - node reply produces a response to the originating station.
// - response: seq 0, size 2, node 4, svc 5, payload from 6.
// - response size counts node through payload, 2 to 498.
// - response node is the node the command went to.
// - success service byte is request service with msb set.
// - failure service byte is 94 hex, payload general and extra code.
// - datagrams use fixed udp port 64000.
// - server only, four outstanding command buffers.
module umg_gateway #(
  parameter int         SRC_W       = 48,
  parameter int         TICK_CYC    = umg_pkg::TMO_UNIT_CYC,
  parameter logic [7:0] TMO_GEN_ERR = 8'h01,
  parameter logic [7:0] TMO_ADD_ERR = 8'hff
) (
  // clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             nrst_i,
  // command datagram stream
  input  wire logic             cmd_valid_i,
  input  wire logic [7:0]       cmd_data_i,
  input  wire logic             cmd_last_i,
  input  wire logic [SRC_W-1:0] cmd_src_i,
  input  wire logic [15:0]      cmd_port_i,
  output logic                  cmd_ready_o,
  // fieldbus request stream
  output logic                  req_valid_o,
  output logic [7:0]            req_data_o,
  output logic                  req_last_o,
  output logic [1:0]            req_tag_o,
  input  wire logic             req_ready_i,
  output logic [3:0]            abort_o,
  // fieldbus reply header
  input  wire logic             rep_hdr_valid_i,
  input  wire logic [1:0]       rep_tag_i,
  input  wire logic             rep_ok_i,
  input  wire logic [8:0]       rep_len_i,
  output logic                  rep_hdr_ready_o,
  // fieldbus reply payload
  input  wire logic             rep_valid_i,
  input  wire logic [7:0]       rep_data_i,
  input  wire logic             rep_last_i,
  output logic                  rep_ready_o,
  // response datagram stream
  output logic                  rsp_valid_o,
  output logic [7:0]            rsp_data_o,
  output logic                  rsp_last_o,
  output logic [SRC_W-1:0]      rsp_dst_o,
  output logic [15:0]           rsp_port_o,
  input  wire logic             rsp_ready_i
);
  localparam int NS = umg_pkg::NSLOT;

  typedef enum logic [1:0] {
    C_HDR  = 2'b00,
    C_FWD  = 2'b01,
    C_DROP = 2'b10
  } umg_cst_t;
  typedef enum logic [1:0] {
    R_IDLE  = 2'b00,
    R_HDR   = 2'b01,
    R_PAY   = 2'b10,
    R_DRAIN = 2'b11
  } umg_rst_t;

  // slot records
  logic [NS-1:0]    busy_q, tmo_q, expire;
  logic [15:0]      seq_q  [NS];
  logic [7:0]       node_q [NS];
  logic [7:0]       svc_q  [NS];
  logic [SRC_W-1:0] src_q  [NS];

  // ten millisecond tick
  logic [31:0] div_q;
  logic        tick_q;
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      div_q  <= 32'h0000_0000;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (div_q == 32'(TICK_CYC - 1));
      div_q  <= (div_q == 32'(TICK_CYC - 1)) ? 32'h0000_0000
                                              : div_q + 32'h0000_0001;
    end
  end

  // ---------------- command side ----------------
  umg_cst_t    c_state_q, c_state_d;
  logic [3:0]  c_idx_q, c_idx_d;
  logic [15:0] h_seq_q, h_tmo_q, h_size_q, rem_q;
  logic [SRC_W-1:0] h_src_q;
  logic        port_ok_q, cmd_ready_q, svc_pend_q;
  logic [1:0]  cur_q, free_idx;
  logic        have_free, size_ok, hdr_go, cmd_take, fwd_take, fwd_end;
  logic        req_valid_q, req_last_q, req_empty_nx, fwd_nx;
  logic [7:0]  req_data_q;
  logic [1:0]  req_tag_q;
  logic [15:0] tmo_load;

  always_comb begin
    have_free = 1'b0;
    free_idx  = 2'd0;
    for (int i = NS - 1; i >= 0; i--) begin
      if (!busy_q[i]) begin
        have_free = 1'b1;
        free_idx  = 2'(i);
      end
    end
  end

  assign cmd_take = cmd_valid_i && cmd_ready_q;
  assign size_ok  = (h_size_q >= umg_pkg::CMD_SIZE_MIN) &&
                    (h_size_q <= umg_pkg::CMD_SIZE_MAX);
  assign hdr_go   = cmd_take && (c_state_q == C_HDR) &&
                    (c_idx_q == umg_pkg::CMD_OFS_NODE) && port_ok_q &&
                    size_ok && have_free &&
                    (cmd_data_i <= umg_pkg::NODE_MAX);
  assign fwd_take = cmd_take && ((c_state_q == C_FWD) || hdr_go);
  assign fwd_end  = fwd_take && (cmd_last_i ||
                    ((c_state_q == C_FWD) && (rem_q == 16'h0001)));
  // zero in the timeout field selects the default
  assign tmo_load = (h_tmo_q == 16'h0000) ? umg_pkg::TMO_DEF_UNITS
                                          : h_tmo_q;

  always_comb begin
    c_state_d = c_state_q;
    c_idx_d   = c_idx_q;
    case (c_state_q)
      C_HDR: begin
        if (cmd_take) begin
          if (hdr_go && !cmd_last_i) begin
            c_state_d = C_FWD;
          end else if (cmd_last_i) begin
            c_idx_d = 4'h0;
          end else if (c_idx_q == umg_pkg::CMD_OFS_NODE) begin
            c_state_d = C_DROP;
          end else begin
            c_idx_d = c_idx_q + 4'h1;
          end
        end
      end
      C_FWD: begin
        if (fwd_take && cmd_last_i) begin
          c_state_d = C_HDR;
        end else if (fwd_end) begin
          c_state_d = C_DROP;
        end
      end
      C_DROP: begin
        if (cmd_take && cmd_last_i) begin
          c_state_d = C_HDR;
        end
      end
      default: c_state_d = C_HDR;
    endcase
    if (c_state_d != C_HDR) begin
      c_idx_d = 4'h0;
    end
  end

  assign req_empty_nx = fwd_take ? 1'b0 : (!req_valid_q || req_ready_i);
  assign fwd_nx = (c_state_d == C_FWD) ||
                  ((c_state_d == C_HDR) &&
                   (c_idx_d == umg_pkg::CMD_OFS_NODE));

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      c_state_q   <= C_HDR;
      c_idx_q     <= 4'h0;
      cmd_ready_q <= 1'b0;
    end else begin
      c_state_q   <= c_state_d;
      c_idx_q     <= c_idx_d;
      // forwarding from the node byte on stalls on the request side; earlier header bytes never do
      cmd_ready_q <= fwd_nx ? (!fwd_take && req_empty_nx) : 1'b1;
    end
  end

  // header capture, low byte first
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      h_seq_q   <= 16'h0000;
      h_tmo_q   <= 16'h0000;
      h_size_q  <= 16'h0000;
      h_src_q   <= '0;
      port_ok_q <= 1'b0;
    end else if (cmd_take && (c_state_q == C_HDR)) begin
      case (c_idx_q)
        umg_pkg::CMD_OFS_SEQ: begin
          h_seq_q[7:0] <= cmd_data_i;
          h_src_q      <= cmd_src_i;
          port_ok_q    <= (cmd_port_i == umg_pkg::UDP_PORT);
        end
        umg_pkg::CMD_OFS_SEQ + 4'h1:  h_seq_q[15:8]  <= cmd_data_i;
        umg_pkg::CMD_OFS_TMO:         h_tmo_q[7:0]   <= cmd_data_i;
        umg_pkg::CMD_OFS_TMO + 4'h1:  h_tmo_q[15:8]  <= cmd_data_i;
        umg_pkg::CMD_OFS_SIZE:        h_size_q[7:0]  <= cmd_data_i;
        umg_pkg::CMD_OFS_SIZE + 4'h1: h_size_q[15:8] <= cmd_data_i;
        default: ;
      endcase
    end
  end

  // node byte onward passes through untouched
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      rem_q       <= 16'h0000;
      cur_q       <= 2'd0;
      svc_pend_q  <= 1'b0;
      req_valid_q <= 1'b0;
      req_data_q  <= 8'h00;
      req_last_q  <= 1'b0;
      req_tag_q   <= 2'd0;
    end else begin
      if (fwd_take) begin
        req_valid_q <= 1'b1;
        req_data_q  <= cmd_data_i;
        req_last_q  <= fwd_end;
        req_tag_q   <= hdr_go ? free_idx : cur_q;
        rem_q       <= hdr_go ? h_size_q - 16'h0001
                              : rem_q - 16'h0001;
        svc_pend_q  <= hdr_go;
      end else if (req_ready_i) begin
        req_valid_q <= 1'b0;
      end
      if (hdr_go) begin
        cur_q <= free_idx;
      end
    end
  end

  // ---------------- slot timers ----------------
  logic [NS-1:0] stop_v;
  logic          hdr_take;
  logic [NS-1:0] abort_q;
  for (genvar g = 0; g < NS; g++) begin : g_tmr
    umg_slot_timer u_tmr (
      .core_clk_i (core_clk_i),
      .nrst_i     (nrst_i),
      .tick_i     (tick_q),
      .start_i    (hdr_go && (free_idx == 2'(g))),
      .load_i     (tmo_load),
      .stop_i     (stop_v[g]),
      .expire_o   (expire[g])
    );
    assign stop_v[g] = hdr_take && (rep_tag_i == 2'(g));
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      abort_q <= '0;
    end else begin
      abort_q <= expire;
    end
  end

  // ---------------- response side ----------------
  umg_rst_t    r_state_q, r_state_d;
  logic [3:0]  r_idx_q;
  logic [1:0]  r_slot_q, pend_idx;
  logic        r_err_q, r_ok_q, any_pend, done, out_load, out_empty_nx;
  logic        hdr_ready_q, rep_ready_q, pay_take, drain_take, hdr_last;
  logic [8:0]  r_len_q;
  logic [15:0] r_size;
  logic [7:0]  r_svc, hdr_byte;
  logic        rsp_valid_q, rsp_last_q;
  logic [7:0]  rsp_data_q;
  logic [SRC_W-1:0] rsp_dst_q;
  logic [15:0] rsp_port_q;

  always_comb begin
    any_pend = 1'b0;
    pend_idx = 2'd0;
    for (int i = NS - 1; i >= 0; i--) begin
      if (tmo_q[i]) begin
        any_pend = 1'b1;
        pend_idx = 2'(i);
      end
    end
  end

  assign hdr_take   = rep_hdr_valid_i && hdr_ready_q;
  assign pay_take   = rep_valid_i && rep_ready_q && (r_state_q == R_PAY);
  assign drain_take = rep_valid_i && rep_ready_q && (r_state_q == R_DRAIN);
  assign r_size     = r_err_q ? umg_pkg::RSP_ERR_SIZE
                              : umg_pkg::RSP_SIZE_MIN + 16'(r_len_q);
  assign r_svc      = (r_err_q || !r_ok_q) ? umg_pkg::SVC_ERR
                      : svc_q[r_slot_q] | umg_pkg::SVC_OK_BIT;
  assign hdr_last   = r_err_q ? (r_idx_q == umg_pkg::RSP_OFS_DATA + 4'h1)
                      : (r_idx_q == umg_pkg::RSP_OFS_SVC);

  always_comb begin
    case (r_idx_q)
      umg_pkg::RSP_OFS_SEQ:         hdr_byte = seq_q[r_slot_q][7:0];
      umg_pkg::RSP_OFS_SEQ + 4'h1:  hdr_byte = seq_q[r_slot_q][15:8];
      umg_pkg::RSP_OFS_SIZE:        hdr_byte = r_size[7:0];
      umg_pkg::RSP_OFS_SIZE + 4'h1: hdr_byte = r_size[15:8];
      umg_pkg::RSP_OFS_NODE:        hdr_byte = node_q[r_slot_q];
      umg_pkg::RSP_OFS_SVC:         hdr_byte = r_svc;
      umg_pkg::RSP_OFS_DATA:        hdr_byte = TMO_GEN_ERR;
      default:                      hdr_byte = TMO_ADD_ERR;
    endcase
  end

  assign out_load = ((r_state_q == R_HDR) && (!rsp_valid_q || rsp_ready_i))
                    || pay_take;
  assign done = ((r_state_q == R_HDR) && out_load && hdr_last &&
                 (r_err_q || (r_len_q == 9'd0))) ||
                (pay_take && rep_last_i);
  assign out_empty_nx = out_load ? 1'b0 : (!rsp_valid_q || rsp_ready_i);

  always_comb begin
    r_state_d = r_state_q;
    case (r_state_q)
      R_IDLE: begin
        if (hdr_take) begin
          if (busy_q[rep_tag_i] && !tmo_q[rep_tag_i]) begin
            r_state_d = R_HDR;
          end else if (rep_len_i != 9'd0) begin
            r_state_d = R_DRAIN;
          end
        end else if (any_pend) begin
          r_state_d = R_HDR;
        end
      end
      R_HDR: begin
        if (done) begin
          r_state_d = R_IDLE;
        end else if (out_load && hdr_last) begin
          r_state_d = R_PAY;
        end
      end
      R_PAY:   if (done) r_state_d = R_IDLE;
      R_DRAIN: if (drain_take && rep_last_i) r_state_d = R_IDLE;
      default: r_state_d = R_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      r_state_q   <= R_IDLE;
      r_idx_q     <= 4'h0;
      r_slot_q    <= 2'd0;
      r_err_q     <= 1'b0;
      r_ok_q      <= 1'b0;
      r_len_q     <= 9'd0;
      hdr_ready_q <= 1'b0;
      rep_ready_q <= 1'b0;
    end else begin
      r_state_q   <= r_state_d;
      hdr_ready_q <= (r_state_q == R_IDLE) && !hdr_take && !any_pend;
      rep_ready_q <= ((r_state_d == R_PAY) && !pay_take && out_empty_nx)
                     || (r_state_d == R_DRAIN);
      if (r_state_q == R_IDLE) begin
        r_idx_q  <= 4'h0;
        r_slot_q <= hdr_take ? rep_tag_i : pend_idx;
        r_err_q  <= !hdr_take;
        r_ok_q   <= rep_ok_i;
        r_len_q  <= rep_len_i;
      end else if ((r_state_q == R_HDR) && out_load) begin
        r_idx_q <= r_idx_q + 4'h1;
      end
    end
  end

  // output byte register
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      rsp_valid_q <= 1'b0;
      rsp_data_q  <= 8'h00;
      rsp_last_q  <= 1'b0;
      rsp_dst_q   <= '0;
      rsp_port_q  <= umg_pkg::UDP_PORT;
    end else begin
      if (out_load) begin
        rsp_valid_q <= 1'b1;
        rsp_data_q  <= pay_take ? rep_data_i : hdr_byte;
        rsp_last_q  <= done;
        rsp_dst_q   <= src_q[r_slot_q];
      end else if (rsp_ready_i) begin
        rsp_valid_q <= 1'b0;
      end
    end
  end

  // slot bookkeeping; allocation only picks idle slots, so no clash
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      busy_q <= '0;
      tmo_q  <= '0;
      for (int i = 0; i < NS; i++) begin
        seq_q[i]  <= 16'h0000;
        node_q[i] <= 8'h00;
        svc_q[i]  <= 8'h00;
        src_q[i]  <= '0;
      end
    end else begin
      if (done) begin
        busy_q[r_slot_q] <= 1'b0;
        tmo_q[r_slot_q]  <= 1'b0;
      end
      tmo_q <= (done ? tmo_q & ~(NS'(1) << r_slot_q) : tmo_q) | expire;
      if (hdr_go) begin
        busy_q[free_idx] <= 1'b1;
        seq_q[free_idx]  <= h_seq_q;
        node_q[free_idx] <= cmd_data_i;
        src_q[free_idx]  <= h_src_q;
      end
      // a datagram cut at its node byte leaves the flag standing
      if (svc_pend_q && fwd_take && !hdr_go) begin
        svc_q[cur_q] <= cmd_data_i;
      end
    end
  end

  assign cmd_ready_o     = cmd_ready_q;
  assign req_valid_o     = req_valid_q;
  assign req_data_o      = req_data_q;
  assign req_last_o      = req_last_q;
  assign req_tag_o       = req_tag_q;
  assign abort_o         = abort_q;
  assign rep_hdr_ready_o = hdr_ready_q;
  assign rep_ready_o     = rep_ready_q;
  assign rsp_valid_o     = rsp_valid_q;
  assign rsp_data_o      = rsp_data_q;
  assign rsp_last_o      = rsp_last_q;
  assign rsp_dst_o       = rsp_dst_q;
  assign rsp_port_o      = rsp_port_q;
endmodule : umg_gateway

// ==== test/umg_gateway_asserts.sv ====
// port assertions for the udp message gateway
`timescale 1ns/100ps
module umg_gateway_asserts #(
  parameter int SRC_W = 48
) (
  // clock and reset
  input wire logic             core_clk_i,
  input wire logic             nrst_i,
  // watched ports
  input wire logic             req_valid_o,
  input wire logic [7:0]       req_data_o,
  input wire logic             req_ready_i,
  input wire logic [3:0]       abort_o,
  input wire logic             rep_hdr_valid_i,
  input wire logic             rep_hdr_ready_o,
  input wire logic             rsp_valid_o,
  input wire logic [7:0]       rsp_data_o,
  input wire logic             rsp_last_o,
  input wire logic [SRC_W-1:0] rsp_dst_o,
  input wire logic [15:0]      rsp_port_o,
  input wire logic             rsp_ready_i
);
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);

  a_port_fixed: assert property (rsp_port_o == 16'hfa00)
    else $error("response port is not 64000");
  a_req_hold: assert property (req_valid_o && !req_ready_i |=>
    req_valid_o && $stable(req_data_o))
    else $error("request byte dropped before taken");
  a_rsp_hold: assert property (rsp_valid_o && !rsp_ready_i |=>
    rsp_valid_o && $stable({rsp_data_o, rsp_last_o}))
    else $error("response byte changed before taken");
  a_abort_pulse: assert property (|abort_o |=>
    (abort_o & $past(abort_o)) == 4'h0)
    else $error("abort longer than one cycle");
  a_dst_stable: assert property (
    rsp_valid_o && !(rsp_ready_i && rsp_last_o) |=> $stable(rsp_dst_o))
    else $error("response station changed mid response");
  a_rsp_latency: assert property (
    rep_hdr_valid_i && rep_hdr_ready_o |-> ##2 rsp_valid_o)
    else $error("response not started two cycles after header");
  a_hdr_busy: assert property (
    rep_hdr_valid_i && rep_hdr_ready_o |=> !rep_hdr_ready_o [*6])
    else $error("header taken while response built");
  // a next response may start at once; its first byte is never last
  a_rsp_end: assert property (
    rsp_valid_o && rsp_ready_i && rsp_last_o |=>
    !(rsp_valid_o && rsp_last_o))
    else $error("last byte repeated after response end");
endmodule : umg_gateway_asserts

bind umg_gateway umg_gateway_asserts #(.SRC_W(SRC_W)) u_asserts (
  .core_clk_i, .nrst_i, .req_valid_o, .req_data_o, .req_ready_i,
  .abort_o, .rep_hdr_valid_i, .rep_hdr_ready_o, .rsp_valid_o,
  .rsp_data_o, .rsp_last_o, .rsp_dst_o, .rsp_port_o, .rsp_ready_i
);

// ==== test/umg_node_model.sv ====
// fieldbus node model: echoes requests, errors or stays silent by node
`timescale 1ns/100ps
module umg_node_model (
  // clock
  input  wire logic       core_clk_i,
  // request stream
  input  wire logic       req_valid_i,
  input  wire logic [7:0] req_data_i,
  input  wire logic       req_last_i,
  input  wire logic [1:0] req_tag_i,
  output logic            req_ready_o,
  // reply
  output logic            hdr_valid_o,
  output logic [1:0]      hdr_tag_o,
  output logic            hdr_ok_o,
  output logic [8:0]      hdr_len_o,
  input  wire logic       hdr_ready_i,
  output logic            dat_valid_o,
  output logic [7:0]      dat_data_o,
  output logic            dat_last_o,
  input  wire logic       dat_ready_i
);
  logic [7:0] q[$];
  logic       last;
  initial begin
    {req_ready_o, hdr_valid_o, hdr_tag_o, hdr_ok_o, hdr_len_o} = '0;
    {dat_valid_o, dat_data_o, dat_last_o} = '0;
    forever begin
      q = {};
      last = 1'b0;
      while (!last) begin
        @(negedge core_clk_i);
        req_ready_o = ($urandom_range(3) != 0);
        @(posedge core_clk_i);
        if (req_valid_i && req_ready_o) begin
          q.push_back(req_data_i);
          hdr_tag_o = req_tag_i;
          last = req_last_i;
        end
      end
      @(negedge core_clk_i);
      req_ready_o = 1'b0;
      // prompt or slow answer
      repeat ($urandom_range(6)) @(negedge core_clk_i);
      // node 63 never answers, so the gateway must time out
      if (q[0] == 8'h3f) continue;
      hdr_ok_o = (q[0] < 8'h30);
      if (!hdr_ok_o) q = {8'h08, q[0]};
      // node 46 answers ok with an empty payload
      else if (q[0] == 8'h2e) q = {};
      hdr_len_o = 9'(q.size());
      hdr_valid_o = 1'b1;
      do @(posedge core_clk_i); while (!hdr_ready_i);
      @(negedge core_clk_i);
      hdr_valid_o = 1'b0;
      foreach (q[i]) begin
        dat_valid_o = 1'b1;
        dat_data_o = q[i];
        dat_last_o = (i == q.size() - 1);
        do @(posedge core_clk_i); while (!dat_ready_i);
        @(negedge core_clk_i);
      end
      dat_valid_o = 1'b0;
      dat_data_o = ~dat_data_o;
    end
  end
endmodule : umg_node_model

// ==== test/tb_umg_gateway.sv ====
// self-checking bench for the udp message gateway
`timescale 1ns/100ps
module tb_umg_gateway;
  typedef logic [7:0] umg_bq_t[$];
  logic        core_clk_i, nrst_i, cmd_valid_i, cmd_last_i, cmd_ready_o;
  logic        req_valid_o, req_last_o, req_ready_i, rep_hdr_valid_i;
  logic        rep_ok_i, rep_hdr_ready_o, rep_valid_i, rep_last_i;
  logic        rep_ready_o, rsp_valid_o, rsp_last_o, rsp_ready_i;
  logic [7:0]  cmd_data_i, req_data_o, rep_data_i, rsp_data_o;
  logic [1:0]  req_tag_o, rep_tag_i;
  logic [3:0]  abort_o;
  logic [8:0]  rep_len_i;
  logic [15:0] cmd_port_i, rsp_port_o;
  logic [47:0] cmd_src_i, rsp_dst_o;
  umg_bq_t     cur, exp_q[int];
  logic [47:0] exp_dst[int];
  int          n_fail, tests_run, n_abort, seq;
  time         t0, t_rsp;

  umg_gateway #(.TICK_CYC(10)) dut (.*);
  umg_node_model u_node (.core_clk_i, .req_valid_i(req_valid_o),
    .req_data_i(req_data_o), .req_last_i(req_last_o),
    .req_tag_i(req_tag_o), .req_ready_o(req_ready_i),
    .hdr_valid_o(rep_hdr_valid_i), .hdr_tag_o(rep_tag_i),
    .hdr_ok_o(rep_ok_i), .hdr_len_o(rep_len_i),
    .hdr_ready_i(rep_hdr_ready_o), .dat_valid_o(rep_valid_i),
    .dat_data_o(rep_data_i), .dat_last_o(rep_last_i),
    .dat_ready_i(rep_ready_o));

  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test

  function automatic umg_bq_t exp_rsp(umg_bq_t c);
    logic [15:0] sz;
    umg_bq_t     r;
    sz = {c[5], c[4]} + 16'h0002;
    r = {c[0], c[1], 8'h04, 8'h00, c[6], 8'h94};
    if (c[6] == 8'h3f) r = {r, 8'h01, 8'hff};
    else if (c[6] > 8'h2f) r = {r, 8'h08, c[6]};
    else r = {c[0], c[1], sz[7:0], sz[15:8], c[6], c[7] | 8'h80, c[6:$]};
    if (c[6] == 8'h2e) r = {c[0], c[1], 8'h02, 8'h00, c[6], c[7] | 8'h80};
    return r;
  endfunction : exp_rsp

  task automatic send(input logic [15:0] sq, tmo, sz,
                      input logic [7:0] node, input logic [15:0] port,
                      input int nb, input bit keep);
    umg_bq_t c;
    int      n;
    n = (nb != 0) ? nb : int'(sz) + 6;
    c = {sq[7:0], sq[15:8], tmo[7:0], tmo[15:8], sz[7:0], sz[15:8], node};
    while (c.size() < n) c.push_back(8'($urandom));
    while (c.size() > n) void'(c.pop_back());
    cmd_src_i = {16'($urandom), 32'($urandom)};
    cmd_port_i = port;
    if (keep) exp_q[int'(sq)] = exp_rsp(c);
    if (keep) exp_dst[int'(sq)] = cmd_src_i;
    foreach (c[i]) begin
      @(negedge core_clk_i);
      cmd_valid_i = 1'b1;
      cmd_data_i = c[i];
      cmd_last_i = (i == c.size() - 1);
      while (!cmd_ready_o) @(negedge core_clk_i);
    end
    @(negedge core_clk_i);
    cmd_valid_i = 1'b0;
    cmd_data_i = ~cmd_data_i;
  endtask : send

  task automatic wait_idle(input int n);
    repeat (n) if (exp_q.size() != 0) @(negedge core_clk_i);
    check(exp_q.size(), 0);
  endtask : wait_idle

  always @(negedge core_clk_i) rsp_ready_i <= ($urandom_range(3) != 0);
  always @(posedge core_clk_i) n_abort += $countones(abort_o);

  always @(posedge core_clk_i) begin
    if (rsp_valid_o && rsp_ready_i) begin
      cur.push_back(rsp_data_o);
      if (rsp_last_o) begin
        seq = int'({cur[1], cur[0]});
        t_rsp = $time;
        check(exp_q.exists(seq), 1);
        if (exp_q.exists(seq)) begin
          check(rsp_dst_o, exp_dst[seq]);
          check(cur.size(), exp_q[seq].size());
          foreach (cur[i]) check(cur[i], exp_q[seq][i]);
          exp_q.delete(seq);
        end
        cur = {};
      end
    end
  end

  initial begin
    #(5 * 80_000);
    n_fail++;
    finish_test();
  end

  initial begin
    void'($urandom(32'he88f));
    {nrst_i, cmd_valid_i, cmd_last_i, cmd_data_i, cmd_src_i} = '0;
    cmd_port_i = 16'hfa00;
    repeat (20) @(negedge core_clk_i);
    nrst_i = 1'b1;
    for (int i = 0; i < 12; i++) begin
      send((i == 0) ? 16'hffff : 16'($urandom),
           16'(500 + $urandom_range(1500)),
           (i == 1) ? 16'h0006 : 16'(6 + $urandom_range(34)),
           (i == 2) ? 8'h2f : (i == 3) ? 8'h2e : 8'($urandom_range(47)),
           16'hfa00, 0, 1);
      wait_idle(3000);
    end
    $display("test forwarding done");
    send(16'h1000, 16'h0800, 16'h01f2, 8'h30, 16'hfa00, 0, 1);
    send(16'h1001, 16'h0800, 16'h0008, 8'h3e, 16'hfa00, 0, 1);
    wait_idle(4000);
    $display("test error replies done");
    send(16'h1100, 16'h0064, 16'h000a, 8'h05, 16'hfa01, 0, 0);
    send(16'h1101, 16'h0064, 16'h0005, 8'h05, 16'hfa00, 0, 0);
    send(16'h1102, 16'h0064, 16'h01f3, 8'h05, 16'hfa00, 0, 0);
    send(16'h1103, 16'h0064, 16'h000a, 8'h40, 16'hfa00, 0, 0);
    send(16'h1104, 16'h0064, 16'h000a, 8'h05, 16'hfa00, 4, 0);
    wait_idle(100);
    $display("test drops done");
    for (int k = 0; k < 4; k++)
      send(16'(16'h2000 + k), 16'h0028, 16'(6 + k), 8'h3f,
           16'hfa00, 0, 1);
    send(16'h2100, 16'h01f4, 16'h0008, 8'h01, 16'hfa00, 0, 0);
    wait_idle(3000);
    check(n_abort, 4);
    $display("test timeout and busy done");
    send(16'h3000, 16'h0000, 16'h0006, 8'h3f, 16'hfa00, 0, 1);
    t0 = $time;
    wait_idle(11000);
    check(((t_rsp - t0) / 5 >= 9950) && ((t_rsp - t0) / 5 <= 10060), 1);
    check(n_abort, 5);
    $display("test default timeout done");
    finish_test();
  end
endmodule : tb_umg_gateway
